/* File: common/bdm_defines.svh */
// address map, field positions and reset values of the banked data memory
`ifndef BDM_DEFINES_SVH
`define BDM_DEFINES_SVH
`define BDM_OFS_IND0       8'h00
`define BDM_OFS_PTR0       8'h01
`define BDM_OFS_PC_LOW     8'h02
`define BDM_OFS_PC_LATCH   8'h03
`define BDM_OFS_ALU        8'h04
`define BDM_OFS_T0CTL      8'h05
`define BDM_OFS_CORE       8'h06
`define BDM_OFS_INTSE      8'h07
`define BDM_OFS_IND1       8'h08
`define BDM_OFS_PTR1       8'h09
`define BDM_OFS_WACC       8'h0a
`define BDM_OFS_T0LO       8'h0b
`define BDM_OFS_T0HI       8'h0c
`define BDM_OFS_TBLO       8'h0d
`define BDM_OFS_TBHI       8'h0e
`define BDM_OFS_BANKSEL    8'h0f
`define BDM_OFS_PROD_LO    8'h18
`define BDM_OFS_PROD_HI    8'h19
`define BDM_PERIPH_LO      8'h10
`define BDM_PERIPH_HI      8'h17
`define BDM_RAM_LO         8'h20
`define BDM_CORE_LAST      8'h0f
`define BDM_RST_PC_LOW     8'h00
`define BDM_RST_PC_LATCH   8'h00
`define BDM_RST_T0CTL      8'h00
`define BDM_RST_INTSE      8'h00
`define BDM_RST_BANKSEL    8'h00
`define BDM_RST_ALU        8'hf0
`define BDM_RST_CORE       8'h3c
`define BDM_PBANK_LSB      0
`define BDM_RBANK_LSB      4
`define BDM_PBANKS         4
`define BDM_RAM_WORDS      454
`define BDM_AV_ADDR_W      8
`endif

/* File: common/bdm_pkg.sv */
// types of the banked data memory
package bdm_pkg;
   typedef logic [7:0] bdm_byte_type;
   typedef enum logic [1:0] {
      BDM_IDLE = 2'b00,
      BDM_ANSWER = 2'b01
   } bdm_state_type;
   typedef enum logic [2:0] {
      BDM_REGION_CORE = 3'b000,
      BDM_REGION_PERIPH = 3'b001,
      BDM_REGION_PROD = 3'b010,
      BDM_REGION_SHARED = 3'b011,
      BDM_REGION_RAM = 3'b100
   } bdm_region_type;
endpackage

/* File: hdl/bdm_data_memory.sv */
// banked data memory map: core registers, peripheral window, ram, avalon slave
`timescale 1ns/1ps
`default_nettype none
`include "bdm_defines.svh"
// Functional notes
// [R1] Addresses 10h-17h select one of four peripheral register banks by the two low bits of the bank selector.
// [R2] Core registers and product registers are reached at their address whatever the bank selector holds.
// [R3] Ram at 20h-FFh is banked by the bank selector high nibble, bank 1 reaching the 120h-1FFh block.
// [R4] Ram at 1Ah-1Fh is shared and ignores the bank selector.
// [R5] Indirect accesses apply the same bank selection as direct ones for banked regions.
// [R6] Ram has no reset and keeps its contents through every reset.
// [R7] Indirect file locations reach the location named by their pointer, holding no storage themselves.
module bdm_data_memory (
   input  wire logic                   clk,
   input  wire logic                   rstn,
   input  wire logic [7:0]             avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   input  wire logic [3:0]             avs_byteenable,
   output logic      [31:0]            avs_readdata,
   output logic      [1:0]             avs_response,
   output logic                        avs_waitrequest,
   output bdm_pkg::bdm_byte_type       bank_selector,
   output bdm_pkg::bdm_byte_type       indirect_pointer_0,
   output bdm_pkg::bdm_byte_type       indirect_pointer_1
);
   import bdm_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      bdm_state_type st;
      bdm_byte_type  ptr0;
      bdm_byte_type  ptr1;
      bdm_byte_type  pc_low;
      bdm_byte_type  pc_latch;
      bdm_byte_type  alu;
      bdm_byte_type  t0ctl;
      bdm_byte_type  core;
      bdm_byte_type  intse;
      bdm_byte_type  wacc;
      bdm_byte_type  t0lo;
      bdm_byte_type  t0hi;
      bdm_byte_type  tblo;
      bdm_byte_type  tbhi;
      bdm_byte_type  banksel;
      bdm_byte_type  prod_lo;
      bdm_byte_type  prod_hi;
      bdm_byte_type  rdata;
      logic          err;
   } bdm_regs_type;

   bdm_regs_type r;
   bdm_regs_type next_r;

   // ram and peripheral banks carry no reset on purpose
   bdm_byte_type ram [`BDM_RAM_WORDS];                            // R6
   bdm_byte_type periph [`BDM_PBANKS*8];

   // ----------------------------------------------------------------
   // address resolution
   // ----------------------------------------------------------------
   logic           is_indirect;
   bdm_byte_type   eff_addr;
   bdm_region_type region;
   logic [8:0]     ram_index;
   logic [4:0]     periph_index;
   logic           ram_bank_bad;
   logic           access;
   logic           ram_we;
   logic           periph_we;
   logic           wr_ok;

   // no store may slip in while reset is held
   assign access = (avs_read | avs_write) & (r.st == BDM_IDLE) & rstn;
   assign wr_ok  = avs_write & avs_byteenable[0];

   always_comb begin
      // indirect slots forward to the pointed location, not their own
      is_indirect = (avs_address == `BDM_OFS_IND0) || (avs_address == `BDM_OFS_IND1);     // R7
      if (avs_address == `BDM_OFS_IND0) begin
         eff_addr = r.ptr0;                                          // R7
      end else if (avs_address == `BDM_OFS_IND1) begin
         eff_addr = r.ptr1;                                          // R7
      end else begin
         eff_addr = avs_address;
      end
      // a pointer naming an indirect slot again reads as zero, no chaining
      if (eff_addr <= `BDM_CORE_LAST) begin
         region = BDM_REGION_CORE;                                   // R2
      end else if (eff_addr <= `BDM_PERIPH_HI) begin
         region = BDM_REGION_PERIPH;                                 // R1 R5
      end else if (eff_addr == `BDM_OFS_PROD_LO || eff_addr == `BDM_OFS_PROD_HI) begin
         region = BDM_REGION_PROD;                                   // R2
      end else if (eff_addr < `BDM_RAM_LO) begin
         region = BDM_REGION_SHARED;                                 // R4
      end else begin
         region = BDM_REGION_RAM;                                    // R3 R5
      end
      periph_index = {r.banksel[`BDM_PBANK_LSB +: 2], eff_addr[2:0]};                      // R1 R5
      ram_bank_bad = r.banksel[`BDM_RBANK_LSB +: 4] > 4'h1;
      if (region == BDM_REGION_SHARED) begin
         ram_index = {4'h0, eff_addr[4:0] - 5'h1a};                                        // R4
      end else begin
         // shared 6 bytes first, then bank 0 (224), then bank 1 (224)
         ram_index = 9'(9'd6 + {1'b0, eff_addr - `BDM_RAM_LO}
                     + (r.banksel[`BDM_RBANK_LSB] ? 9'd224 : 9'd0));                        // R3 R5
      end
      ram_we    = access & wr_ok & ((region == BDM_REGION_SHARED)
                  | ((region == BDM_REGION_RAM) & ~ram_bank_bad));
      periph_we = access & wr_ok & (region == BDM_REGION_PERIPH);
   end

   // ----------------------------------------------------------------
   // storage without reset
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (ram_we) begin
         ram[ram_index] <= avs_writedata[7:0];                       // R6
      end
      if (periph_we) begin
         periph[periph_index] <= avs_writedata[7:0];                 // R1
      end
   end

   // ----------------------------------------------------------------
   // registers and bus answer
   // ----------------------------------------------------------------
   bdm_byte_type rd_value;
   logic         rd_err;

   always_comb begin
      rd_value = 8'h00;
      rd_err   = 1'b0;
      unique case (region)
         BDM_REGION_CORE: begin
            unique case (eff_addr)
               `BDM_OFS_PTR0:    rd_value = r.ptr0;
               `BDM_OFS_PC_LOW:   rd_value = r.pc_low;
               `BDM_OFS_PC_LATCH: rd_value = r.pc_latch;
               `BDM_OFS_ALU:     rd_value = r.alu;
               `BDM_OFS_T0CTL:   rd_value = r.t0ctl;
               `BDM_OFS_CORE:    rd_value = r.core;
               `BDM_OFS_INTSE:   rd_value = r.intse;
               `BDM_OFS_PTR1:    rd_value = r.ptr1;
               `BDM_OFS_WACC:    rd_value = r.wacc;
               `BDM_OFS_T0LO:    rd_value = r.t0lo;
               `BDM_OFS_T0HI:    rd_value = r.t0hi;
               `BDM_OFS_TBLO:    rd_value = r.tblo;
               `BDM_OFS_TBHI:    rd_value = r.tbhi;
               `BDM_OFS_BANKSEL: rd_value = r.banksel;
               default:          rd_value = 8'h00;
            endcase
         end
         BDM_REGION_PERIPH: rd_value = periph[periph_index];
         BDM_REGION_PROD:   rd_value = eff_addr[0] ? r.prod_hi : r.prod_lo;
         BDM_REGION_SHARED: rd_value = ram[ram_index];
         BDM_REGION_RAM: begin
            rd_err   = ram_bank_bad;
            rd_value = ram_bank_bad ? 8'h00 : ram[ram_index];
         end
      endcase
   end

   always_comb begin
      next_r = r;
      unique case (r.st)
         BDM_IDLE: begin
            if (access) begin
               next_r.st    = BDM_ANSWER;
               next_r.rdata = avs_read ? rd_value : 8'h00;
               next_r.err   = rd_err;
               if (wr_ok && region == BDM_REGION_CORE) begin
                  unique case (eff_addr)
                     `BDM_OFS_PTR0:    next_r.ptr0    = avs_writedata[7:0];
                     `BDM_OFS_PC_LOW:   next_r.pc_low   = avs_writedata[7:0];
                     `BDM_OFS_PC_LATCH: next_r.pc_latch = avs_writedata[7:0];
                     `BDM_OFS_ALU:     next_r.alu     = avs_writedata[7:0];
                     `BDM_OFS_T0CTL:   next_r.t0ctl   = {avs_writedata[7:1], 1'b0};
                     `BDM_OFS_CORE:    next_r.core    = {2'b00, avs_writedata[5:4], r.core[3:2], 2'b00};
                     `BDM_OFS_INTSE:   next_r.intse   = avs_writedata[7:0];
                     `BDM_OFS_PTR1:    next_r.ptr1    = avs_writedata[7:0];
                     `BDM_OFS_WACC:    next_r.wacc    = avs_writedata[7:0];
                     `BDM_OFS_T0LO:    next_r.t0lo    = avs_writedata[7:0];
                     `BDM_OFS_T0HI:    next_r.t0hi    = avs_writedata[7:0];
                     `BDM_OFS_TBLO:    next_r.tblo    = avs_writedata[7:0];
                     `BDM_OFS_TBHI:    next_r.tbhi    = avs_writedata[7:0];
                     `BDM_OFS_BANKSEL: next_r.banksel = avs_writedata[7:0];
                     default:          next_r.pc_low  = r.pc_low;
                  endcase
               end else if (wr_ok && region == BDM_REGION_PROD) begin
                  if (eff_addr[0]) begin
                     next_r.prod_hi = avs_writedata[7:0];            // R2
                  end else begin
                     next_r.prod_lo = avs_writedata[7:0];            // R2
                  end
               end
               if (avs_write && region == BDM_REGION_RAM && ram_bank_bad) begin
                  next_r.err = 1'b1;
               end
            end
         end
         BDM_ANSWER: begin
            next_r.st = BDM_IDLE;
         end
         default: next_r.st = BDM_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         r         <= '0;
         r.pc_low   <= `BDM_RST_PC_LOW;
         r.pc_latch <= `BDM_RST_PC_LATCH;
         r.t0ctl   <= `BDM_RST_T0CTL;
         r.intse   <= `BDM_RST_INTSE;
         r.banksel <= `BDM_RST_BANKSEL;
         r.alu     <= `BDM_RST_ALU;
         r.core    <= `BDM_RST_CORE;
      end else begin
         r <= next_r;
      end
   end

   assign avs_waitrequest    = ~(r.st == BDM_ANSWER);
   assign avs_readdata       = {24'h000000, r.rdata};
   assign avs_response       = r.err ? 2'b10 : 2'b00;
   assign bank_selector      = r.banksel;
   assign indirect_pointer_0 = r.ptr0;
   assign indirect_pointer_1 = r.ptr1;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_ANSWER_NEXT: assert property (@(posedge clk) disable iff (!rstn)
      (r.st == BDM_IDLE && (avs_read || avs_write)) |=> !avs_waitrequest)
      else $error("answer not one cycle after request");
   AST_PERIPH_BANK: assert property (@(posedge clk) disable iff (!rstn) // R1
      (access && region == BDM_REGION_PERIPH) |-> periph_index[4:3] == r.banksel[1:0])
      else $error("peripheral bank not taken from bank selector");
   AST_CORE_UNBANKED: assert property (@(posedge clk) disable iff (!rstn) // R2
      (access && avs_read && avs_address == `BDM_OFS_BANKSEL) |=> avs_readdata[7:0] == $past(r.banksel))
      else $error("core register read wrong");
   AST_RAM_BANK: assert property (@(posedge clk) disable iff (!rstn) // R3
      (access && region == BDM_REGION_RAM && r.banksel[4]) |-> ram_index >= 9'd230)
      else $error("ram bank 1 not selected");
   AST_SHARED: assert property (@(posedge clk) disable iff (!rstn) // R4
      (access && region == BDM_REGION_SHARED) |-> ram_index < 9'd6)
      else $error("shared ram banked");
   AST_INDIRECT_BANK: assert property (@(posedge clk) disable iff (!rstn) // R5
      (access && avs_address == `BDM_OFS_IND0 && region == BDM_REGION_PERIPH)
      |-> periph_index == {r.banksel[1:0], r.ptr0[2:0]})
      else $error("indirect access ignored bank selector");
   AST_INDIRECT_PTR: assert property (@(posedge clk) disable iff (!rstn) // R7
      (access && avs_address == `BDM_OFS_IND1) |-> eff_addr == r.ptr1)
      else $error("indirect slot not forwarded");
   AST_WAIT_IDLE: assert property (@(posedge clk) disable iff (!rstn)
      !avs_waitrequest |=> avs_waitrequest)
      else $error("answer stood two cycles");
   AST_RESET_IDLE: assert property (@(posedge clk)
      !rstn |=> (avs_waitrequest && bank_selector == `BDM_RST_BANKSEL))
      else $error("bus not idle after reset");
   AST_RESET_NO_STORE: assert property (@(posedge clk) // R6
      !rstn |-> !(ram_we || periph_we))
      else $error("storage written during reset");
   AST_UPPER_ZERO: assert property (@(posedge clk) disable iff (!rstn)
      !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
      else $error("upper read data not zero");
   AST_BAD_BANK_ERR: assert property (@(posedge clk) disable iff (!rstn) // R3
      (access && region == BDM_REGION_RAM && r.banksel[7:5] != 3'h0) |=> avs_response == 2'b10)
      else $error("ram bank above one not refused");
   AST_UNBANKED_OK: assert property (@(posedge clk) disable iff (!rstn) // R2
      (access && region != BDM_REGION_RAM) |=> avs_response == 2'b00)
      else $error("error answer outside banked ram");
   AST_BAD_BANK_NO_WRITE: assert property (@(posedge clk) disable iff (!rstn) // R3
      (region == BDM_REGION_RAM && ram_bank_bad) |-> !ram_we)
      else $error("write reached a missing ram bank");
   AST_BYTE_LANE: assert property (@(posedge clk) disable iff (!rstn)
      (access && avs_write && !avs_byteenable[0]) |-> !(ram_we || periph_we))
      else $error("write without low byte lane stored");
   AST_NO_CHAIN: assert property (@(posedge clk) disable iff (!rstn) // R7
      (access && is_indirect && (eff_addr == `BDM_OFS_IND0 || eff_addr == `BDM_OFS_IND1))
      |-> (rd_value == 8'h00 && !ram_we && !periph_we))
      else $error("indirect slot chained through itself");
   AST_RAM_RANGE: assert property (@(posedge clk) disable iff (!rstn) // R3
      (access && (region == BDM_REGION_RAM || region == BDM_REGION_SHARED)) |-> ram_index < 9'(`BDM_RAM_WORDS))
      else $error("ram index beyond storage");
   AST_RAM_BANK0: assert property (@(posedge clk) disable iff (!rstn) // R3
      (access && region == BDM_REGION_RAM && !r.banksel[4]) |-> (ram_index >= 9'd6 && ram_index < 9'd230))
      else $error("ram bank 0 not selected");
   AST_PTR_WRITE: assert property (@(posedge clk) disable iff (!rstn) // R7
      (access && wr_ok && avs_address == `BDM_OFS_PTR0) |=> indirect_pointer_0 == $past(avs_writedata[7:0]))
      else $error("pointer write lost");
   AST_BANKSEL_WRITE: assert property (@(posedge clk) disable iff (!rstn) // R1
      (access && wr_ok && avs_address == `BDM_OFS_BANKSEL) |=> bank_selector == $past(avs_writedata[7:0]))
      else $error("bank selector write lost");
   AST_T0CTL_BIT0: assert property (@(posedge clk) disable iff (!rstn)
      r.t0ctl[0] == 1'b0)
      else $error("timer control bit 0 set");
   AST_CORE_FIXED: assert property (@(posedge clk) disable iff (!rstn)
      (r.core[7:6] == 2'b00 && r.core[3:2] == 2'b11 && r.core[1:0] == 2'b00))
      else $error("core status fixed bits changed");
   AST_PROD_UNBANKED: assert property (@(posedge clk) disable iff (!rstn) // R2
      (access && avs_read && avs_address == `BDM_OFS_PROD_LO) |=> avs_readdata[7:0] == $past(r.prod_lo))
      else $error("product register read wrong");
endmodule
`default_nettype wire

/* File: test/bdm_core_model.sv */
// core-side model: issues single-byte avalon-mm accesses to the data memory
`timescale 1ns/1ps
`default_nettype none
module bdm_core_model (
   input  wire logic        clk,
   input  wire logic        avs_waitrequest,
   output logic      [7:0]  avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic      [31:0] avs_writedata,
   output logic      [3:0]  avs_byteenable
);
   initial begin
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
   end
   // gap idles the bus first, so prompt and slow callers are both seen
   task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                         input int gap);
      int n;
      repeat (gap + 1) @(posedge clk);
      avs_address <= a;
      avs_read <= ~wr;
      avs_write <= wr;
      avs_writedata <= d;
      avs_byteenable <= be;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 64);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // stale data is inverted so nothing can lean on it
      avs_writedata <= ~d;
   endtask
endmodule
`default_nettype wire

/* File: test/banked_data_memory_map_tb_top.sv */
// self-checking bench of the banked data memory map
`timescale 1ns/1ps
`default_nettype none
module banked_data_memory_map_tb_top;
   import bdm_pkg::*;
   logic             clk = 1'b0;
   logic             rstn = 1'b0;
   logic [7:0]       avs_address;
   logic             avs_read;
   logic             avs_write;
   logic [31:0]      avs_writedata;
   logic [3:0]       avs_byteenable;
   logic [31:0]      avs_readdata;
   logic [1:0]       avs_response;
   logic             avs_waitrequest;
   bdm_byte_type     bank_selector;
   bdm_byte_type     indirect_pointer_0;
   bdm_byte_type     indirect_pointer_1;
   logic [33:0]      exp_q[$];
   int               bad_count = 0;
   int               checked = 0;
   always #12.5 clk = ~clk;
   bdm_core_model i_core (.clk(clk), .avs_waitrequest(avs_waitrequest), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));
   bdm_data_memory i_dut (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_response(avs_response), .avs_waitrequest(avs_waitrequest),
      .bank_selector(bank_selector), .indirect_pointer_0(indirect_pointer_0),
      .indirect_pointer_1(indirect_pointer_1));
   //------------------------------------------------------------
   // checking
   //------------------------------------------------------------
   task automatic check(input logic [33:0] seen, input logic [33:0] want);
      checked++;
      if (seen !== want) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic test_done();
      if (exp_q.size() != 0) begin
         bad_count++;
      end
      $display("checked %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_core.access(1'b1, a, {24'($urandom), d}, 4'hf, int'($urandom_range(2)));
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] d);
      exp_q.push_back({2'b00, 24'h0, d});
      i_core.access(1'b0, a, $urandom, 4'hf, int'($urandom_range(2)));
   endtask
   always @(posedge clk) begin
      if (rstn === 1'b1 && avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         if (exp_q.size() == 0) begin
            check(34'h1, 34'h0);
         end else begin
            check({avs_response, avs_readdata}, exp_q.pop_front());
         end
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      test_done();
   end
   //------------------------------------------------------------
   // tests
   //------------------------------------------------------------
   initial begin
      logic [7:0] pv [0:3][0:7];
      logic [7:0] ra [0:6];
      logic [7:0] rv [0:6];
      logic [7:0] v0;
      logic [7:0] v1;
      logic [7:0] v2;
      ra = '{8'h02, 8'h03, 8'h05, 8'h07, 8'h0f, 8'h04, 8'h06};
      rv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hf0, 8'h3c};
      void'($urandom(84));
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      check({26'h0, bank_selector}, 34'h0);
      for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
      wr(8'h05, 8'hff);
      rd(8'h05, 8'hfe);
      wr(8'h06, 8'h00);
      rd(8'h06, 8'h0c);
      $display("reset values done");
      for (int b = 0; b < 4; b++) begin
         wr(8'h0f, 8'(b));
         for (int i = 0; i < 8; i++) begin
            pv[b][i] = 8'($urandom);
            wr(8'h10 + 8'(i), pv[b][i]);
         end
      end
      for (int b = 3; b >= 0; b--) begin
         wr(8'h0f, 8'(b));
         for (int i = 0; i < 8; i++) rd(8'h10 + 8'(i), pv[b][i]);
      end
      $display("peripheral banks done");
      v0 = 8'($urandom);
      v1 = 8'($urandom);
      v2 = 8'($urandom);
      wr(8'h18, v0);
      wr(8'h0a, v1);
      wr(8'h0f, 8'h13);
      rd(8'h18, v0);
      rd(8'h0a, v1);
      rd(8'h0f, 8'h13);
      rd(8'h10, pv[3][0]);
      $display("unbanked registers done");
      wr(8'h0f, 8'h00);
      wr(8'h20, v0);
      wr(8'hff, v1);
      wr(8'h1a, v2);
      wr(8'h1f, ~v2);
      wr(8'h40, v1);
      wr(8'h0f, 8'h10);
      wr(8'h20, ~v0);
      wr(8'hff, ~v1);
      rd(8'h1a, v2);
      rd(8'h1f, ~v2);
      rd(8'h20, ~v0);
      rd(8'hff, ~v1);
      wr(8'h0f, 8'h00);
      rd(8'h20, v0);
      rd(8'hff, v1);
      i_core.access(1'b1, 8'h20, 32'h0000005a, 4'he, 0);
      rd(8'h20, v0);
      wr(8'h0f, 8'h20);
      i_core.access(1'b1, 8'h20, {24'h0, ~v0}, 4'hf, 0);
      exp_q.push_back({2'b10, 32'h0});
      i_core.access(1'b0, 8'h20, 32'h0, 4'hf, 0);
      wr(8'h0f, 8'h00);
      rd(8'h20, v0);
      $display("ram banks done");
      wr(8'h0f, 8'h10);
      wr(8'h01, 8'h40);
      wr(8'h00, v2);
      wr(8'h09, 8'h1a);
      wr(8'h08, ~v1);
      rd(8'h40, v2);
      rd(8'h1a, ~v1);
      check({26'h0, indirect_pointer_0}, 34'h40);
      check({26'h0, indirect_pointer_1}, 34'h1a);
      wr(8'h0f, 8'h00);
      rd(8'h00, v1);
      wr(8'h01, 8'h08);
      rd(8'h00, 8'h00);
      $display("indirect access done");
      @(posedge clk);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      check({26'h0, bank_selector}, 34'h0);
      rd(8'h20, v0);
      rd(8'h1f, ~v2);
      wr(8'h0f, 8'h10);
      rd(8'h20, ~v0);
      $display("ram through reset done");
      repeat (4) @(posedge clk);
      test_done();
   end
endmodule
`default_nettype wire
